// ===== core/gpx_expander.sv
// Top of the 16-bit port expander: two-wire bus slave, pointer, pin levels.
// Assumes bus clock and data arrive as plain pins sampled by clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module gpx_expander (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic slave_select_pin_0_i,
  input wire logic slave_select_pin_1_i,
  input wire logic slave_select_pin_2_i,
  input wire logic [7:0] low_port_pin_i,
  output logic [7:0] low_port_pin_o,
  output logic [7:0] low_port_pin_oe_o,
  input wire logic [7:0] high_port_pin_i,
  output logic [7:0] high_port_pin_o,
  output logic [7:0] high_port_pin_oe_o
);

  logic rst_n;
  logic scl_s;
  logic sda_s;
  logic [2:0] sel_s;
  gpx_pkg::gpx_port_type pin_s;
  logic scl_d;
  logic sda_d;
  gpx_pkg::gpx_state_type state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic nack_r;
  logic [2:0] ptr_r;
  gpx_pkg::gpx_wreq_type wreq_r;
  gpx_pkg::gpx_port_type level_r;
  gpx_pkg::gpx_port_type drive_w;
  gpx_pkg::gpx_port_type invert_w;
  gpx_pkg::gpx_port_type dir_w;
  logic [7:0] bank_rd_w;
  logic [7:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_full;
  logic addr_hit;
  logic rx_state;

  // Reset release through two flops
  gpx_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(nrst_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // All pin inputs pass two flops; bus lines idle high
  gpx_sync #(.W(21), .RST_VAL(21'h180000)) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .d_i({scl_i, sda_i, slave_select_pin_2_i, slave_select_pin_1_i,
          slave_select_pin_0_i, high_port_pin_i, low_port_pin_i}),
    .q_o({scl_s, sda_s, sel_s, pin_s})
  );

  // Stored registers and their registered read port
  gpx_reg_bank u_bank (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .wreq_i(wreq_r),
    .rd_addr_i(ptr_r),
    .rd_data_o(bank_rd_w),
    .drive_o(drive_w),
    .invert_o(invert_w),
    .dir_o(dir_w)
  );

  // Previous bus line values for edge and condition detection
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus events and byte decode
  always_comb begin
    scl_rise = scl_s && !scl_d;
    scl_fall = !scl_s && scl_d;
    start_det = scl_s && scl_d && sda_d && !sda_s;
    stop_det = scl_s && scl_d && !sda_d && sda_s;
    byte_full = (cnt_r == gpx_pkg::GPX_BYTE_CNT);
    addr_hit = (shift_r[7:1] == {gpx_pkg::GPX_ADDR_PREFIX, sel_s});
    rx_state = (state_r == gpx_pkg::GPX_S_ADDR) || (state_r == gpx_pkg::GPX_S_CMD) ||
               (state_r == gpx_pkg::GPX_S_WDATA);
  end

  // Byte to send: pin-level pair from here, the rest from the bank
  // read source select
  always_comb begin
    if (ptr_r[2:1] == gpx_pkg::GPX_PIN_LEVEL_LO[2:1]) begin
      rd_byte = ptr_r[gpx_pkg::GPX_PAIR_BIT] ? level_r.hi : level_r.lo;
    end else begin
      rd_byte = bank_rd_w;
    end
  end

  // Sampled pin levels with optional inversion
  // follow pins every cycle
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= '0;
    end else begin
      level_r <= pin_s ^ invert_w;
    end
  end

  // Bus engine state
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= gpx_pkg::GPX_S_IDLE;
    end else if (start_det) begin
      state_r <= gpx_pkg::GPX_S_ADDR;
    end else if (stop_det) begin
      state_r <= gpx_pkg::GPX_S_IDLE;
    end else if (scl_fall) begin
      case (state_r)
        gpx_pkg::GPX_S_ADDR: begin
          if (byte_full) begin
            state_r <= addr_hit ? gpx_pkg::GPX_S_ADDR_ACK : gpx_pkg::GPX_S_IDLE;
          end
        end
        gpx_pkg::GPX_S_ADDR_ACK: begin
          state_r <= rw_r ? gpx_pkg::GPX_S_RDATA : gpx_pkg::GPX_S_CMD;
        end
        gpx_pkg::GPX_S_CMD: begin
          if (byte_full) begin
            state_r <= gpx_pkg::GPX_S_CMD_ACK;
          end
        end
        gpx_pkg::GPX_S_CMD_ACK: begin
          state_r <= gpx_pkg::GPX_S_WDATA;
        end
        gpx_pkg::GPX_S_WDATA: begin
          if (byte_full) begin
            state_r <= gpx_pkg::GPX_S_WDATA_ACK;
          end
        end
        gpx_pkg::GPX_S_WDATA_ACK: begin
          state_r <= gpx_pkg::GPX_S_WDATA;
        end
        gpx_pkg::GPX_S_RDATA: begin
          if (byte_full) begin
            state_r <= gpx_pkg::GPX_S_RDATA_ACK;
          end
        end
        gpx_pkg::GPX_S_RDATA_ACK: begin
          state_r <= nack_r ? gpx_pkg::GPX_S_IDLE : gpx_pkg::GPX_S_RDATA;
        end
        default: begin
          state_r <= gpx_pkg::GPX_S_IDLE;
        end
      endcase
    end
  end

  // Bit counter, receive shifter and direction bit
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
    end else if (start_det) begin
      cnt_r <= 4'h0;
    end else if (rx_state && scl_rise && !byte_full) begin
      shift_r <= {shift_r[6:0], sda_s};
      cnt_r <= cnt_r + 4'h1;
    end else if (scl_fall) begin
      if (state_r == gpx_pkg::GPX_S_ADDR && byte_full) begin
        rw_r <= shift_r[0];
      end else if (state_r == gpx_pkg::GPX_S_ADDR_ACK) begin
        cnt_r <= rw_r ? 4'h1 : 4'h0;
      end else if (state_r == gpx_pkg::GPX_S_CMD_ACK ||
                   state_r == gpx_pkg::GPX_S_WDATA_ACK) begin
        cnt_r <= 4'h0;
      end else if (state_r == gpx_pkg::GPX_S_RDATA && !byte_full) begin
        cnt_r <= cnt_r + 4'h1;
      end else if (state_r == gpx_pkg::GPX_S_RDATA_ACK) begin
        cnt_r <= 4'h1;
      end
    end
  end

  // Data line drive: acknowledge low, or read bits, open-drain style
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_o <= 1'b0;
      tx_r <= 8'h00;
    end else if (start_det || stop_det) begin
      sda_oe_o <= 1'b0;
    end else if (scl_fall) begin
      case (state_r)
        gpx_pkg::GPX_S_ADDR: begin
          if (byte_full) begin
            sda_oe_o <= addr_hit;
          end
        end
        gpx_pkg::GPX_S_CMD, gpx_pkg::GPX_S_WDATA: begin
          if (byte_full) begin
            sda_oe_o <= 1'b1;
          end
        end
        gpx_pkg::GPX_S_ADDR_ACK: begin
          sda_oe_o <= rw_r && !rd_byte[7];
          tx_r <= {rd_byte[6:0], 1'b0};
        end
        gpx_pkg::GPX_S_RDATA: begin
          sda_oe_o <= !byte_full && !tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
        gpx_pkg::GPX_S_RDATA_ACK: begin
          sda_oe_o <= !nack_r && !rd_byte[7];
          tx_r <= {rd_byte[6:0], 1'b0};
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Data line level is always low when enabled
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Register pointer and master acknowledge capture
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ptr_r <= gpx_pkg::GPX_PTR_RST;
      nack_r <= 1'b0;
    end else if (scl_fall && byte_full && state_r == gpx_pkg::GPX_S_CMD) begin
      ptr_r <= shift_r[2:0];
    end else if (scl_fall && byte_full && state_r == gpx_pkg::GPX_S_WDATA) begin
      ptr_r[gpx_pkg::GPX_PAIR_BIT] <= !ptr_r[gpx_pkg::GPX_PAIR_BIT];
    end else if (scl_rise && state_r == gpx_pkg::GPX_S_RDATA_ACK) begin
      ptr_r[gpx_pkg::GPX_PAIR_BIT] <= !ptr_r[gpx_pkg::GPX_PAIR_BIT];
      nack_r <= sda_s;
    end
  end

  // Write request after a full data byte
  // pin-level pair never written
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wreq_r <= '0;
    end else begin
      wreq_r.we <= scl_fall && byte_full && state_r == gpx_pkg::GPX_S_WDATA &&
                   (ptr_r[2:1] != gpx_pkg::GPX_PIN_LEVEL_LO[2:1]);
      wreq_r.addr <= ptr_r;
      wreq_r.data <= shift_r;
    end
  end

  // Port pin drivers
  // enable from direction
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      low_port_pin_o <= gpx_pkg::GPX_DRIVE_RST;
      high_port_pin_o <= gpx_pkg::GPX_DRIVE_RST;
      low_port_pin_oe_o <= 8'h00;
      high_port_pin_oe_o <= 8'h00;
    end else begin
      low_port_pin_o <= drive_w.lo;
      high_port_pin_o <= drive_w.hi;
      low_port_pin_oe_o <= ~dir_w.lo;
      high_port_pin_oe_o <= ~dir_w.hi;
    end
  end

  property p_oe_dir;
    @(posedge clk_sys_i) disable iff (!rst_n)
    ##1 ({high_port_pin_oe_o, low_port_pin_oe_o} == ~$past(dir_w)) &&
        ({high_port_pin_o, low_port_pin_o} == $past(drive_w));
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin drive mismatch");

  property p_ro_write;
    @(posedge clk_sys_i) disable iff (!rst_n)
    wreq_r.we |-> (wreq_r.addr[2:1] != 2'b00);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to pin-level register");

  property p_level_invert;
    @(posedge clk_sys_i) disable iff (!rst_n)
    ##1 (level_r == ($past(pin_s) ^ $past(invert_w)));
  endproperty
  a_level_invert: assert property (p_level_invert) else $error("pin level wrong");

  property p_cmd_ptr;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (scl_fall && byte_full && state_r == gpx_pkg::GPX_S_CMD && !start_det && !stop_det)
      |=> (ptr_r == $past(shift_r[2:0])) && (state_r == gpx_pkg::GPX_S_CMD_ACK) && sda_oe_o;
  endproperty
  a_cmd_ptr: assert property (p_cmd_ptr) else $error("pointer not loaded");

  property p_wr_alt;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (scl_fall && byte_full && state_r == gpx_pkg::GPX_S_WDATA && !start_det && !stop_det)
      |=> (ptr_r[0] != $past(ptr_r[0])) && (ptr_r[2:1] == $past(ptr_r[2:1]));
  endproperty
  a_wr_alt: assert property (p_wr_alt) else $error("write pointer not toggled");

  property p_rd_alt;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (scl_rise && state_r == gpx_pkg::GPX_S_RDATA_ACK && !start_det && !stop_det)
      |=> (ptr_r[0] != $past(ptr_r[0])) && (nack_r == $past(sda_s));
  endproperty
  a_rd_alt: assert property (p_rd_alt) else $error("read pointer not toggled");

  property p_addr_ack;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (scl_fall && byte_full && state_r == gpx_pkg::GPX_S_ADDR && !start_det && !stop_det)
      |=> (sda_oe_o == (state_r == gpx_pkg::GPX_S_ADDR_ACK)) &&
          (sda_oe_o == ($past(shift_r[7:1]) == {4'h4, $past(sel_s)}));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");

  property p_write_lands;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (wreq_r.we && wreq_r.addr == 3'h3) |=> (drive_w.hi == $past(wreq_r.data)) ##1
      (high_port_pin_o == $past(drive_w.hi));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("drive write not seen");

endmodule : gpx_expander
`default_nettype wire

// ===== core/gpx_reg_bank.sv
// Drive-level, invert-sense and pin-direction register pairs.
// Assumes writes never target the pin-level pair; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module gpx_reg_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire gpx_pkg::gpx_wreq_type wreq_i,
  input wire logic [2:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output gpx_pkg::gpx_port_type drive_o,
  output gpx_pkg::gpx_port_type invert_o,
  output gpx_pkg::gpx_port_type dir_o
);

  // Register writes, decoded by pointer value
  // power-on values
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_o <= {gpx_pkg::GPX_DRIVE_RST, gpx_pkg::GPX_DRIVE_RST};
      invert_o <= {gpx_pkg::GPX_INVERT_RST, gpx_pkg::GPX_INVERT_RST};
      dir_o <= {gpx_pkg::GPX_DIRECTION_RST, gpx_pkg::GPX_DIRECTION_RST};
    end else if (wreq_i.we) begin
      if (wreq_i.addr == gpx_pkg::GPX_DRIVE_LEVEL_LO) begin
        drive_o.lo <= wreq_i.data;
      end else if (wreq_i.addr == gpx_pkg::GPX_DRIVE_LEVEL_HI) begin
        drive_o.hi <= wreq_i.data;
      end else if (wreq_i.addr == gpx_pkg::GPX_INVERT_SENSE_LO) begin
        invert_o.lo <= wreq_i.data;
      end else if (wreq_i.addr == gpx_pkg::GPX_INVERT_SENSE_HI) begin
        invert_o.hi <= wreq_i.data;
      end else if (wreq_i.addr == gpx_pkg::GPX_PIN_DIRECTION_LO) begin
        dir_o.lo <= wreq_i.data;
      end else if (wreq_i.addr == gpx_pkg::GPX_PIN_DIRECTION_HI) begin
        dir_o.hi <= wreq_i.data;
      end
    end
  end

  // Registered read port; pin-level pair is served by the caller
  // stored value read back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_addr_i == gpx_pkg::GPX_DRIVE_LEVEL_LO) begin
      rd_data_o <= drive_o.lo;
    end else if (rd_addr_i == gpx_pkg::GPX_DRIVE_LEVEL_HI) begin
      rd_data_o <= drive_o.hi;
    end else if (rd_addr_i == gpx_pkg::GPX_INVERT_SENSE_LO) begin
      rd_data_o <= invert_o.lo;
    end else if (rd_addr_i == gpx_pkg::GPX_INVERT_SENSE_HI) begin
      rd_data_o <= invert_o.hi;
    end else if (rd_addr_i == gpx_pkg::GPX_PIN_DIRECTION_LO) begin
      rd_data_o <= dir_o.lo;
    end else if (rd_addr_i == gpx_pkg::GPX_PIN_DIRECTION_HI) begin
      rd_data_o <= dir_o.hi;
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  property p_drive_readback;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rd_addr_i == gpx_pkg::GPX_DRIVE_LEVEL_HI) |=> (rd_data_o == $past(drive_o.hi));
  endproperty
  a_drive_readback: assert property (p_drive_readback) else $error("drive readback wrong");

  property p_rst_values;
    @(posedge clk_i)
    $rose(rst_n_i) |-> (drive_o == 16'hFFFF && dir_o == 16'hFFFF && invert_o == 16'h0000);
  endproperty
  a_rst_values: assert property (p_rst_values) else $error("reset values wrong");

endmodule : gpx_reg_bank
`default_nettype wire

// ===== core/gpx_sync.sv
// Two-flop synchroniser for a group of levels from outside the clock domain.
// Assumes the reset given is asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module gpx_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule : gpx_sync
`default_nettype wire

// ===== inc/gpx_pkg.sv
// Shared constants, types and state codes for the 16-bit port expander.
// Assumes a single system clock; every user writes gpx_pkg::name.
package gpx_pkg;

  // Register indices selected by the low three pointer bits
  localparam logic [2:0] GPX_PIN_LEVEL_LO = 3'h0;
  localparam logic [2:0] GPX_PIN_LEVEL_HI = 3'h1;
  localparam logic [2:0] GPX_DRIVE_LEVEL_LO = 3'h2;
  localparam logic [2:0] GPX_DRIVE_LEVEL_HI = 3'h3;
  localparam logic [2:0] GPX_INVERT_SENSE_LO = 3'h4;
  localparam logic [2:0] GPX_INVERT_SENSE_HI = 3'h5;
  localparam logic [2:0] GPX_PIN_DIRECTION_LO = 3'h6;
  localparam logic [2:0] GPX_PIN_DIRECTION_HI = 3'h7;

  // Values after power-on reset
  localparam logic [7:0] GPX_DRIVE_RST = 8'hFF;
  localparam logic [7:0] GPX_INVERT_RST = 8'h00;
  localparam logic [7:0] GPX_DIRECTION_RST = 8'hFF;
  localparam logic [2:0] GPX_PTR_RST = 3'h0;

  // Bits in one bus byte, and the fixed upper slave address bits
  localparam logic [3:0] GPX_BYTE_CNT = 4'h8;
  localparam logic [3:0] GPX_ADDR_PREFIX = 4'h4;

  // Bit position of the pair selector inside the pointer
  localparam int GPX_PAIR_BIT = 0;

  // One register pair: high port and low port
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } gpx_port_type;

  // Register write request from the bus engine
  typedef struct packed {
    logic we;
    logic [2:0] addr;
    logic [7:0] data;
  } gpx_wreq_type;

  // Bus engine states, Gray coded along the usual path
  typedef enum logic [3:0] {
    GPX_S_IDLE = 4'h0,
    GPX_S_ADDR = 4'h1,
    GPX_S_ADDR_ACK = 4'h3,
    GPX_S_CMD = 4'h2,
    GPX_S_CMD_ACK = 4'h6,
    GPX_S_WDATA = 4'h7,
    GPX_S_WDATA_ACK = 4'h5,
    GPX_S_RDATA = 4'h4,
    GPX_S_RDATA_ACK = 4'hC
  } gpx_state_type;

endpackage : gpx_pkg

// ===== sim/gpx_bus_master.sv
// Behavioural two-wire bus master: drives SCL and pulls SDA low.
// Assumes SDA has a pull-up and calls begin on a system-clock falling edge.
`timescale 1ns/1ps
`default_nettype none
module gpx_bus_master (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // Idle bus: clock stands high, data released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // One bit out, 48 ns a bit, data moves only while SCL is low
  task automatic bit_out(input logic b);
    #12 sda_pull_o = ~b;
    #12 scl_o = 1'b1;
    #24 scl_o = 1'b0;
  endtask : bit_out
  // One bit in, sampled in the middle of the high phase
  task automatic bit_in(output logic b);
    #12 sda_pull_o = 1'b0;
    #12 scl_o = 1'b1;
    #12 b = sda_i;
    #12 scl_o = 1'b0;
  endtask : bit_in
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    #12 sda_pull_o = 1'b0;
    #12 scl_o = 1'b1;
    #24 sda_pull_o = 1'b1;
    #24 scl_o = 1'b0;
  endtask : start
  // Stop: SDA rises while SCL is high, clock then stays high
  task automatic stop();
    #12 sda_pull_o = 1'b1;
    #12 scl_o = 1'b1;
    #24 sda_pull_o = 1'b0;
    #24;
  endtask : stop
  // Byte out MSB first, then the slave acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask : send_byte
  // Byte in MSB first, then our ack or nack
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(~ack);
  endtask : recv_byte
endmodule : gpx_bus_master
`default_nettype wire

// ===== sim/tb_gpio_expander_register_bank.sv
// Self-checking bench for the port expander register bank.
// Assumes the expander top and the bus master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_expander_register_bank;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] sel = 3'h5;
  logic [7:0] ext_lo = 8'h5C;
  logic [7:0] ext_hi = 8'hA3;
  logic scl, m_pull, sda_o, sda_oe, sda_w;
  logic [7:0] lo_o, lo_oe, hi_o, hi_oe, pad_lo, pad_hi;
  logic [7:0] exp_r [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF};
  logic [2:0] ptr = 3'h0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;
  // Open-drain data line with pull-up; pads resolve driver against outside level
  assign sda_w = ~m_pull & ~(sda_oe & ~sda_o);
  assign pad_lo = (lo_o & lo_oe) | (ext_lo & ~lo_oe);
  assign pad_hi = (hi_o & hi_oe) | (ext_hi & ~hi_oe);

  gpx_expander u_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .slave_select_pin_0_i(sel[0]),
    .slave_select_pin_1_i(sel[1]), .slave_select_pin_2_i(sel[2]),
    .low_port_pin_i(pad_lo), .low_port_pin_o(lo_o), .low_port_pin_oe_o(lo_oe),
    .high_port_pin_i(pad_hi), .high_port_pin_o(hi_o), .high_port_pin_oe_o(hi_oe)
  );
  gpx_bus_master u_master (.sda_i(sda_w), .scl_o(scl), .sda_pull_o(m_pull));

  // Verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      n_mismatch++;
    end
  endtask : chk

  // Expected read value of one register from the bench's own model
  function automatic logic [7:0] expv(input logic [2:0] p);
    logic [7:0] pad;
    pad = p[0] ? (exp_r[3] & ~exp_r[7]) | (ext_hi & exp_r[7])
               : (exp_r[2] & ~exp_r[6]) | (ext_lo & exp_r[6]);
    return (p > 3'h1) ? exp_r[p] : pad ^ exp_r[{2'b10, p[0]}];
  endfunction : expv

  task automatic addr(input logic rd);
    logic ack;
    u_master.send_byte({gpx_pkg::GPX_ADDR_PREFIX, sel, rd}, ack);
    chk({7'h00, ack}, 8'h01);
  endtask : addr

  // Write n bytes after a command, tracking the pair alternation
  task automatic wr(input logic [7:0] cmd, input logic [23:0] d, input int n);
    logic ack;
    @(negedge clk_sys_i);
    u_master.start();
    addr(1'b0);
    u_master.send_byte(cmd, ack);
    chk({7'h00, ack}, 8'h01);
    ptr = cmd[2:0];
    for (int k = 0; k < n; k++) begin
      u_master.send_byte(d[23-8*k -: 8], ack);
      if (ptr > 3'h1) exp_r[ptr] = d[23-8*k -: 8];
      ptr[0] = ~ptr[0];
    end
    u_master.stop();
  endtask : wr

  // Read n bytes, with a command and restart or from the current pointer
  task automatic rd(input logic use_cmd, input logic [2:0] cmd, input int n);
    logic ack;
    logic [7:0] d;
    @(negedge clk_sys_i);
    u_master.start();
    if (use_cmd) begin
      addr(1'b0);
      u_master.send_byte({5'h00, cmd}, ack);
      ptr = cmd;
      u_master.start();
    end
    addr(1'b1);
    for (int k = 0; k < n; k++) begin
      u_master.recv_byte(k < n - 1, d);
      chk(d, expv(ptr));
      ptr[0] = ~ptr[0];
    end
    u_master.stop();
  endtask : rd

  task automatic chk_pins();
    chk(lo_oe, ~exp_r[6]);
    chk(hi_oe, ~exp_r[7]);
    chk(lo_o, exp_r[2]);
    chk(hi_o, exp_r[3]);
  endtask : chk_pins

  task automatic rd_all();
    for (int p = 0; p < 8; p++) begin
      rd(1'b1, p[2:0], 1);
    end
  endtask : rd_all

  task automatic t_reset();
    chk_pins();
    rd_all();
  endtask : t_reset

  task automatic t_pairs();
    wr(8'h02, 24'hA53C96, 3);
    rd(1'b1, 3'h2, 3);
    chk_pins();
  endtask : t_pairs

  task automatic t_dir();
    wr(8'h07, 24'h0FF000, 2);
    chk_pins();
    rd(1'b1, 3'h0, 2);
    @(negedge clk_sys_i);
    ext_lo = 8'hC3;
    ext_hi = 8'h3C;
    rd(1'b1, 3'h1, 2);
  endtask : t_dir

  task automatic t_inv();
    wr(8'h05, 24'hF00F00, 2);
    rd(1'b1, 3'h0, 2);
  endtask : t_inv

  task automatic t_ro();
    wr(8'hF8, 24'h123400, 2);
    rd_all();
    chk_pins();
  endtask : t_ro

  task automatic t_restart();
    rd(1'b1, 3'h3, 1);
    rd(1'b0, 3'h0, 2);
  endtask : t_restart

  // Foreign address refused, own address served; then the straps move
  task automatic t_addr();
    logic ack;
    for (int s = 0; s < 2; s++) begin
      @(negedge clk_sys_i);
      u_master.start();
      u_master.send_byte({gpx_pkg::GPX_ADDR_PREFIX, sel ^ 3'h7, 1'b0}, ack);
      chk({7'h00, ack}, 8'h00);
      u_master.stop();
      rd(1'b1, 3'h6, 1);
      // New strap value; the old address must no longer answer
      @(negedge clk_sys_i);
      sel = 3'h2;
    end
  endtask : t_addr

  // Main sequence
  initial begin
    repeat (20) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    t_reset();
    t_pairs();
    t_dir();
    t_inv();
    t_ro();
    t_restart();
    t_addr();
    finish_test();
  end
endmodule : tb_gpio_expander_register_bank
`default_nettype wire
